/* File: sampling_adc_host_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_regs.svh"

module sampling_adc_host_port
	import adc_port_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic CONVERT_START_IN,
	input wire logic POWER_DOWN_IN,
	input wire logic CS_N_IN,
	input wire logic RD_N_IN,
	input wire logic WR_N_IN,
	input wire logic CFG_IN_BIT1,
	input wire logic CFG_IN_BIT0,
	input wire logic [13:0] RESULT_BUS_IN,
	output logic [13:0] RESULT_BUS_OUT,
	output logic [13:0] RESULT_BUS_OE,
	output logic CONV_DONE_N,
	output logic TRACK_OUT,
	output logic LOW_POWER_OUT,
	output logic CORE_START,
	output logic [3:0] CFG_WORD,
	input wire logic [13:0] CORE_WORD,
	input wire logic CORE_VALID,
	output logic CORE_READY
);

	localparam logic [7:0] CONV_COUNT = 8'(`CONV_CYCLES);

	// Awake and not converting: the states that accept a convert-start edge
	function automatic logic idle_state(input state_t s);
		return (s == ST_TRACK) || (s == ST_DONE);
	endfunction

	// True in the cycle that moves the block into a conversion
	function automatic logic conv_entry(input state_t now, input state_t nxt);
		return (nxt == ST_CONVERT) && (now != ST_CONVERT);
	endfunction

	// Pin synchronisation
	logic [`PIN_COUNT-1:0] raw_pins;
	logic [`PIN_COUNT-1:0] pins;
	logic result_bit1_cfg_bit3;
	logic result_bit0_cfg_bit2;

	assign result_bit1_cfg_bit3 = RESULT_BUS_IN[1];
	assign result_bit0_cfg_bit2 = RESULT_BUS_IN[0];
	assign raw_pins = {result_bit1_cfg_bit3, result_bit0_cfg_bit2, CFG_IN_BIT1, CFG_IN_BIT0,
		WR_N_IN, RD_N_IN, CS_N_IN, POWER_DOWN_IN, CONVERT_START_IN};

	// Stages reset to each pin's idle level,
	// so no false strobe edge or configuration write follows reset
	pin_sync #(
		.WIDTH(`PIN_COUNT),
		.IDLE(`PIN_IDLE)
	) u_sync (
		.clk(CLK_SYS),
		.rst(RESET),
		.pin_in(raw_pins),
		.pin_out(pins)
	);

	logic convert_start_in;
	logic power_down_in;
	logic cs_active;
	logic rd_n;
	logic wr_n;
	cfg_t cfg_in;

	assign convert_start_in = pins[`PIN_CONV_START];
	assign power_down_in = pins[`PIN_PDOWN];
	assign cs_active = !pins[`PIN_CS_N];
	assign rd_n = pins[`PIN_RD_N];
	assign wr_n = pins[`PIN_WR_N];
	assign cfg_in = {pins[`PIN_BUS1], pins[`PIN_BUS0], pins[`PIN_CFG1], pins[`PIN_CFG0]};

	// Edge detection on the agreed (already filtered) levels
	logic conv_start_prev_ff;
	logic rd_n_prev_ff;
	logic wr_n_prev_ff;
	logic cs_prev_ff;
	logic conv_start_rise;
	logic rd_rise;
	logic wr_rise;

	// Read and write strobe edges count only if chip select was low during the access
	assign conv_start_rise = convert_start_in && !conv_start_prev_ff;
	assign rd_rise = rd_n && !rd_n_prev_ff && cs_prev_ff;
	assign wr_rise = wr_n && !wr_n_prev_ff && cs_prev_ff;

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			conv_start_prev_ff <= 1'b0;
			rd_n_prev_ff <= 1'b1;
			wr_n_prev_ff <= 1'b1;
			cs_prev_ff <= 1'b0;
		end else begin
			conv_start_prev_ff <= convert_start_in;
			rd_n_prev_ff <= rd_n;
			wr_n_prev_ff <= wr_n;
			cs_prev_ff <= cs_active;
		end
	end

	// Configuration register, never touched by sleep
	// Writes are taken in any state, even mid-conversion or asleep
	cfg_t cfg_ff;
	cfg_t nxt_cfg;
	logic mode_bit;

	assign nxt_cfg = wr_rise ? cfg_in : cfg_ff;
	assign mode_bit = cfg_ff[`CFG_BIT_MODE];

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			cfg_ff <= `CFG_RESET;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	// Control state
	state_t state_ff;
	state_t nxt_state;
	logic [7:0] timer_ff;
	logic [7:0] nxt_timer;
	logic [3:0] stored_ff;
	logic [3:0] nxt_stored;
	logic all_stored;
	logic conv_finish;

	assign all_stored = (stored_ff == 4'(`NUM_CHANNELS));
	// Done needs the full time and every channel, so a slow core stretches it
	assign conv_finish = (state_ff == ST_CONVERT) && (timer_ff == 8'h00) && all_stored;

	// Edges in sleep or mid-conversion are dropped without any sign to the host
	logic start_seen;
	assign start_seen = conv_start_rise && idle_state(state_ff);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_SLEEP: begin
				if (!power_down_in) begin
					nxt_state = ST_TRACK;
				end
			end
			ST_TRACK: begin
				if (start_seen) begin
					nxt_state = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (conv_finish) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (start_seen) begin
					nxt_state = ST_CONVERT;
				end
			end
		endcase
		// Power-down overrides any state, including a conversion in flight
		if (power_down_in) begin
			nxt_state = ST_SLEEP;
		end
	end

	// Conversion timer covers the internal conversion time
	assign nxt_timer = conv_entry(state_ff, nxt_state) ? CONV_COUNT - 8'h01 :
		(timer_ff != 8'h00) ? timer_ff - 8'h01 : 8'h00;

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			state_ff <= ST_SLEEP;
			timer_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
		end
	end

	// Result path: core words pass a two-entry buffer into the channel store
	result_t buf_data;
	logic buf_valid;
	logic buf_ready;
	logic buf_flush;
	logic store_word;
	logic start_conv;

	assign start_conv = conv_entry(state_ff, nxt_state);
	// Flushing on every start keeps words of an aborted conversion out of the next
	assign buf_flush = start_conv || (state_ff == ST_SLEEP);
	// Store stalls once every channel is in, so late words back up into the core
	assign buf_ready = (state_ff == ST_CONVERT) && !all_stored;
	assign store_word = buf_valid && buf_ready;
	assign nxt_stored = start_conv ? 4'h0 : (store_word ? stored_ff + 4'h1 : stored_ff);

	skid_buffer2 u_buf (
		.clk(CLK_SYS),
		.rst(RESET),
		.flush(buf_flush),
		.in_data(CORE_WORD),
		.in_valid(CORE_VALID),
		.in_ready(CORE_READY),
		.out_data(buf_data),
		.out_valid(buf_valid),
		.out_ready(buf_ready)
	);

	result_t chan_mem [`NUM_CHANNELS];

	always_ff @(posedge CLK_SYS) begin
		if (store_word) begin
			chan_mem[stored_ff[2:0]] <= buf_data;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			stored_ff <= 4'h0;
		end else begin
			stored_ff <= nxt_stored;
		end
	end

	// Read pointer wraps after the last channel, so a ninth read gives channel 0 again
	chan_t rd_ptr_ff;
	chan_t nxt_rd_ptr;
	logic [3:0] reads_ff;
	logic [3:0] nxt_reads;

	assign nxt_rd_ptr = conv_finish ? 3'h0 : (rd_rise ? rd_ptr_ff + 3'h1 : rd_ptr_ff);
	assign nxt_reads = conv_finish ? 4'h0 :
		((rd_rise && reads_ff != 4'(`NUM_CHANNELS)) ? reads_ff + 4'h1 : reads_ff);

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			rd_ptr_ff <= 3'h0;
			reads_ff <= 4'h0;
		end else begin
			rd_ptr_ff <= nxt_rd_ptr;
			reads_ff <= nxt_reads;
		end
	end

	// Outputs, each from a flip-flop
	logic read_active;
	logic sleep_next;
	logic nxt_track;
	logic nxt_done_n;
	result_t nxt_bus;

	assign sleep_next = (nxt_state == ST_SLEEP);
	// Bus is driven only while chip select and read are both low and the block is awake
	assign read_active = cs_active && !rd_n && !sleep_next;
	assign nxt_bus = read_active ? chan_mem[nxt_rd_ptr] : `RESULT_IDLE;
	// Mode 0 tracks while convert-start is low; mode 1 tracks whenever idle
	assign nxt_track = idle_state(nxt_state) &&
		(!convert_start_in || mode_bit);
	assign nxt_done_n = !(nxt_state == ST_DONE);

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			RESULT_BUS_OUT <= `RESULT_IDLE;
			RESULT_BUS_OE <= 14'h0000;
			CONV_DONE_N <= 1'b1;
			TRACK_OUT <= 1'b0;
			LOW_POWER_OUT <= 1'b1;
			CORE_START <= 1'b0;
			CFG_WORD <= `CFG_RESET;
		end else begin
			RESULT_BUS_OUT <= nxt_bus;
			RESULT_BUS_OE <= {14{read_active}};
			CONV_DONE_N <= nxt_done_n;
			TRACK_OUT <= nxt_track;
			LOW_POWER_OUT <= sleep_next;
			CORE_START <= start_conv;
			CFG_WORD <= nxt_cfg;
		end
	end

endmodule // sampling_adc_host_port

`default_nettype wire

/* File: adc_port_regs.svh */
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// Conversion timing at the 50 MHz system clock
`define CLK_PERIOD_NS 20
`define CONV_TIME_NS 3000
// Least time, so the count rounds up
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Configuration word layout and reset value
`define CFG_RESET 4'h0
`define CFG_BIT_MODE 0
`define CFG_BIT_IN0 0
`define CFG_BIT_IN1 1
`define CFG_BIT_BUS0 2
`define CFG_BIT_BUS1 3

// Positions inside the synchronised pin vector
`define PIN_CONV_START 0
`define PIN_PDOWN 1
`define PIN_CS_N 2
`define PIN_RD_N 3
`define PIN_WR_N 4
`define PIN_CFG0 5
`define PIN_CFG1 6
`define PIN_BUS0 7
`define PIN_BUS1 8
`define PIN_COUNT 9
// Idle level of each pin, loaded into the synchroniser at reset
`define PIN_IDLE 9'h19E

`define NUM_CHANNELS 8
`define LAST_CHANNEL 3'h7
`define RESULT_IDLE 14'h0000

`endif

/* File: adc_port_pkg.sv */
package adc_port_pkg;

	typedef logic [13:0] result_t;
	typedef logic [2:0] chan_t;
	typedef logic [3:0] cfg_t;

	typedef enum logic [3:0] {
		ST_SLEEP = 4'h1,
		ST_TRACK = 4'h2,
		ST_CONVERT = 4'h4,
		ST_DONE = 4'h8
	} state_t;

endpackage

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] agreed_ff;

	assign pin_out = agreed_ff;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			// A change is taken only once the last two stages agree
			always_ff @(posedge clk or posedge rst) begin
				// Reset loads the idle level so that no false edge follows reset
				if (rst) begin
					stage1_ff[g] <= IDLE[g];
					stage2_ff[g] <= IDLE[g];
					stage3_ff[g] <= IDLE[g];
					agreed_ff[g] <= IDLE[g];
				end else begin
					stage1_ff[g] <= pin_in[g];
					stage2_ff[g] <= stage1_ff[g];
					stage3_ff[g] <= stage2_ff[g];
					if (stage2_ff[g] == stage3_ff[g]) begin
						agreed_ff[g] <= stage3_ff[g];
					end
				end
			end
		end
	endgenerate

endmodule // pin_sync

`default_nettype wire

/* File: skid_buffer2.sv */
`timescale 1ns/1ps
`default_nettype none

module skid_buffer2
	import adc_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire result_t in_data,
	input wire logic in_valid,
	output logic in_ready,
	output result_t out_data,
	output logic out_valid,
	input wire logic out_ready
);

	result_t slot_ff [2];
	logic rd_sel_ff;
	logic wr_sel_ff;
	logic [1:0] count_ff;
	logic ready_ff;
	logic push;
	logic pop;
	logic [1:0] nxt_count;

	assign push = in_valid && ready_ff;
	assign pop = out_valid && out_ready;
	assign nxt_count = flush ? 2'h0 : 2'(count_ff + {1'b0, push} - {1'b0, pop});
	assign in_ready = ready_ff;
	assign out_valid = (count_ff != 2'h0);
	assign out_data = slot_ff[rd_sel_ff];

	// Ready is registered, so it drops one word early rather than risk a lost word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_ff <= 2'h0;
			ready_ff <= 1'b0;
			rd_sel_ff <= 1'b0;
			wr_sel_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			ready_ff <= !flush && (nxt_count == 2'h0 || (nxt_count == 2'h1 && !push));
			rd_sel_ff <= flush ? 1'b0 : rd_sel_ff ^ pop;
			wr_sel_ff <= flush ? 1'b0 : wr_sel_ff ^ push;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			slot_ff[wr_sel_ff] <= in_data;
		end
	end

endmodule // skid_buffer2

`default_nettype wire

/* File: adc_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_port_sva (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic POWER_DOWN_IN,
	input wire logic CS_N_IN,
	input wire logic RD_N_IN,
	input wire logic WR_N_IN,
	input wire logic [13:0] RESULT_BUS_OE,
	input wire logic CONV_DONE_N,
	input wire logic TRACK_OUT,
	input wire logic LOW_POWER_OUT,
	input wire logic CORE_START,
	input wire logic [3:0] CFG_WORD,
	input wire logic CORE_READY
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	chk_oe_whole: assert property (RESULT_BUS_OE == 14'h0 || RESULT_BUS_OE == 14'h3FFF)
		else $error("bus enable split");
	// Seven cycles covers the pin synchroniser plus the output register
	chk_cs_release: assert property (CS_N_IN [*7] |-> RESULT_BUS_OE == 14'h0)
		else $error("bus driven while deselected");
	chk_rd_release: assert property (RD_N_IN [*7] |-> RESULT_BUS_OE == 14'h0)
		else $error("bus driven without read");
	chk_sleep_state: assert property (POWER_DOWN_IN [*7] |-> LOW_POWER_OUT && CONV_DONE_N)
		else $error("not asleep");
	chk_sleep_ready: assert property (LOW_POWER_OUT |=> !CORE_READY)
		else $error("core words accepted while asleep");
	chk_start_done: assert property (CORE_START |-> CONV_DONE_N && !TRACK_OUT)
		else $error("start without done high");
	chk_start_once: assert property (CORE_START |=> !CORE_START [*8])
		else $error("start repeated");
	chk_done_wait: assert property ($fell(CONV_DONE_N) |-> $past(CONV_DONE_N, 150) && !LOW_POWER_OUT)
		else $error("done too early");
	chk_cfg_hold: assert property ($changed(CFG_WORD) |-> !$past(WR_N_IN, 7) && !$past(CS_N_IN, 7))
		else $error("config changed without write");
	cover property (CORE_START);
	cover property ($fell(CONV_DONE_N));
	cover property ($rose(LOW_POWER_OUT));
	cover property ($rose(RESULT_BUS_OE[0]));
endmodule // adc_port_sva
bind sampling_adc_host_port adc_port_sva chk_u (.CLK_SYS(CLK_SYS), .RESET(RESET),
	.POWER_DOWN_IN(POWER_DOWN_IN), .CS_N_IN(CS_N_IN), .RD_N_IN(RD_N_IN), .WR_N_IN(WR_N_IN),
	.RESULT_BUS_OE(RESULT_BUS_OE), .CONV_DONE_N(CONV_DONE_N), .TRACK_OUT(TRACK_OUT),
	.LOW_POWER_OUT(LOW_POWER_OUT), .CORE_START(CORE_START), .CFG_WORD(CFG_WORD),
	.CORE_READY(CORE_READY));
`default_nettype wire

/* File: core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic ready,
	input wire logic slow,
	output logic [13:0] word,
	output logic valid
);
	logic [3:0] left_ff;
	logic [10:0] conv_ff;
	logic tick_ff;
	logic [13:0] val;
	// Eight words per start, channel 0 first
	assign val = {conv_ff, 3'h0 - left_ff[2:0]};
	assign valid = left_ff != 4'h0 && (!slow || tick_ff);
	// Idle data is inverted so a stale word never passes
	assign word = valid ? val : ~val;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_ff <= 4'h0;
			conv_ff <= 11'h000;
			tick_ff <= 1'b0;
		end else begin
			if (!valid || ready) tick_ff <= ~tick_ff;
			if (start) begin
				left_ff <= 4'h8;
				conv_ff <= conv_ff + 11'h001;
			end else if (valid && ready) begin
				left_ff <= left_ff - 4'h1;
			end
		end
	end
endmodule // core_model
`default_nettype wire

/* File: sampling_adc_host_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sampling_adc_host_port_tb;
	import adc_port_pkg::*;
	logic clk = 1'b0, rst = 1'b1, conv = 1'b0, pd = 1'b0;
	logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, slow = 1'b0, host_en = 1'b0, oe_prev = 1'b0;
	cfg_t cfg_pin = 4'h0, cfg_exp = 4'h0, cfg_word;
	logic [13:0] bus_pin, bus_out, bus_oe, core_word;
	logic done_n, track, low_pwr, start, core_valid, core_ready;
	result_t exp_q[$];
	result_t want;
	int errors = 0, samples_checked = 0;
	logic [7:0] rnd = 8'h04;
	logic [10:0] nconv = 11'h000;
`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
	// Idle bus is pulled up
	assign bus_pin = bus_oe[0] ? bus_out : (host_en ? {12'hFFF, cfg_pin[3:2]} : 14'h3FFF);
	initial forever #10 clk = ~clk;
	sampling_adc_host_port dut_u (.CLK_SYS(clk), .RESET(rst), .CONVERT_START_IN(conv),
		.POWER_DOWN_IN(pd), .CS_N_IN(cs_n), .RD_N_IN(rd_n), .WR_N_IN(wr_n),
		.CFG_IN_BIT1(cfg_pin[1]), .CFG_IN_BIT0(cfg_pin[0]), .RESULT_BUS_IN(bus_pin),
		.RESULT_BUS_OUT(bus_out), .RESULT_BUS_OE(bus_oe), .CONV_DONE_N(done_n),
		.TRACK_OUT(track), .LOW_POWER_OUT(low_pwr), .CORE_START(start), .CFG_WORD(cfg_word),
		.CORE_WORD(core_word), .CORE_VALID(core_valid), .CORE_READY(core_ready));
	core_model core_u (.clk(clk), .rst(rst), .start(start), .ready(core_ready), .slow(slow),
		.word(core_word), .valid(core_valid));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic give_verdict();
		`CHECK("pending", 0, exp_q.size())
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic write_cfg(input cfg_t v, input logic sel_n);
		cs_n = sel_n;
		host_en = 1'b1;
		cfg_pin = v;
		tick(4);
		wr_n = 1'b0;
		tick(4);
		wr_n = 1'b1;
		tick(4);
		cs_n = 1'b1;
		host_en = 1'b0;
		if (!sel_n) cfg_exp = v;
		tick(4);
		`CHECK("cfg", cfg_exp, cfg_word)
	endtask
	task automatic read_all(input int n);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back({nconv, i[2:0]});
			cs_n = 1'b0;
			rd_n = 1'b0;
			tick(8);
			rd_n = 1'b1;
			tick(4);
			cs_n = 1'b1;
			tick(4);
		end
	endtask
	task automatic fire_start();
		conv = 1'b1;
		tick(8);
		conv = 1'b0;
	endtask
	task automatic finish(input int lo, input logic trk);
		int n;
		n = 0;
		`CHECK("done_hi", 1'b1, done_n)
		while (done_n !== 1'b0 && n < 400) begin
			tick(1);
			n++;
		end
		`CHECK("done_time", 1'b1, n >= lo && n < 400)
		tick(8);
		`CHECK("track", trk, track)
	endtask
	// Results are compared mid-cycle, once the output register has settled
	always @(negedge clk) begin
		if (bus_oe[0] === 1'b1 && !oe_prev) begin
			want = exp_q.size() > 0 ? exp_q.pop_front() : 14'h0;
			`CHECK("result", want, bus_out)
		end
		oe_prev <= bus_oe[0] === 1'b1;
	end
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
	initial begin
		tick(2);
		rst = 1'b0;
		tick(10);
		`CHECK("cfg_rst", 4'h0, cfg_word)
		write_cfg(4'hA, 1'b1);
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			write_cfg(rnd[3:0], rnd[4]);
		end
		write_cfg(4'h0, 1'b0);
		fire_start();
		nconv++;
		finish(145, 1'b1);
		read_all(9);
		slow = 1'b1;
		fire_start();
		nconv++;
		tick(30);
		// Refused edge mid-conversion, then held high: mode 0 stops tracking
		conv = 1'b1;
		finish(0, 1'b0);
		conv = 1'b0;
		read_all(8);
		write_cfg(4'h5, 1'b0);
		pd = 1'b1;
		tick(10);
		`CHECK("sleep", 2'b11, {low_pwr, done_n})
		`CHECK("sleep_ready", 1'b0, core_ready)
		fire_start();
		cs_n = 1'b0;
		rd_n = 1'b0;
		tick(8);
		`CHECK("sleep_bus", 14'h0, bus_oe)
		cs_n = 1'b1;
		rd_n = 1'b1;
		pd = 1'b0;
		tick(10);
		`CHECK("cfg_keep", cfg_exp, cfg_word)
		// Mode 1 keeps tracking after done although convert-start stays high
		conv = 1'b1;
		nconv++;
		finish(145, 1'b1);
		conv = 1'b0;
		read_all(8);
		give_verdict();
	end
endmodule // sampling_adc_host_port_tb
`default_nettype wire
